// *** src/ssi_pkg.sv ***
package ssi_pkg;

	// ==========================================================
	// Widths and limits.
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W  = 4;
	localparam logic [CNT_W-1:0]  CNT_MAX  = 4'hf;
	localparam logic [CNT_W-1:0]  CNT_ZERO = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// ==========================================================
	// Wire mode encodings.
	localparam logic [1:0] WM_OFF      = 2'h0;
	localparam logic [1:0] WM_THREE    = 2'h1;
	localparam logic [1:0] WM_TWO      = 2'h2;
	localparam logic [1:0] WM_TWO_HOLD = 2'h3;

	// ==========================================================
	// Control word, bit 7 down to bit 0.
	typedef struct packed {
		logic       start_ie;
		logic       ovf_ie;
		logic [1:0] wire_mode;
		logic       external_clock_select;
		logic       clock_edge_select;
		logic       clock_strobe_bit;
		logic       clock_pin_toggle_strobe;
	} ssi_ctrl_s;

	// ==========================================================
	// Status word: flags in bits 7 to 4, counter in bits 3 to 0.
	typedef struct packed {
		logic             start_condition_flag;
		logic             counter_overflow_flag;
		logic             stop_flag;
		logic             collision_flag;
		logic [CNT_W-1:0] cnt;
	} ssi_status_s;

	localparam ssi_ctrl_s   CTRL_RST = 8'h00;
	localparam ssi_status_s STAT_RST = 8'h00;

endpackage : ssi_pkg

// *** src/ssi_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssi_sync2 #(
	parameter int unsigned WIDTH = 2
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Asynchronous levels and their synchronised copies.
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	// ==========================================================
	// Two flip-flop synchroniser.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule : ssi_sync2

`default_nettype wire

// *** src/ssi_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssi_counter #(
	parameter int unsigned WIDTH = 4
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Count and load.
	input  wire logic             tick,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	// Value and wrap.
	output var  logic [WIDTH-1:0] cnt_q,
	output var  logic             wrap
);

	logic [WIDTH-1:0] cnt_d;

	// ==========================================================
	// A load takes precedence over a count in the same cycle.
	assign wrap  = tick && !load && (cnt_q == {WIDTH{1'b1}});
	assign cnt_d = load ? load_val : (tick ? WIDTH'(cnt_q + 1'b1) : cnt_q);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule : ssi_counter

`default_nettype wire

// *** src/ssi_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssi_core (
	// Clock and reset.
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// Shift data register access.
	input  wire logic                    data_wr,
	input  wire logic [7:0]              data_wdata,
	output var  logic [7:0]              shift_data_q,
	// Control register access.
	input  wire logic                    ctrl_wr,
	input  wire ssi_pkg::ssi_ctrl_s      ctrl_wdata,
	output var  ssi_pkg::ssi_ctrl_s      ctrl_q,
	// Status register access.
	input  wire logic                    stat_wr,
	input  wire ssi_pkg::ssi_status_s    stat_wdata,
	output var  ssi_pkg::ssi_status_s    status_q,
	// Port direction bits and timer.
	input  wire logic                    data_out_dir,
	input  wire logic                    clock_dir,
	input  wire logic                    timer0_match,
	// Pins.
	input  wire logic                    data_in_pin_i,
	output var  logic                    data_in_pin_o_q,
	output var  logic                    data_in_pin_oe_q,
	output var  logic                    data_out_pin_o_q,
	output var  logic                    data_out_pin_oe_q,
	input  wire logic                    shift_clock_pin_i,
	output var  logic                    shift_clock_pin_o_q,
	output var  logic                    shift_clock_pin_oe_q,
	// Requests.
	output var  logic                    start_irq_q,
	output var  logic                    ovf_irq_q,
	output var  logic                    idle_wake_q
);

	import ssi_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection.
	logic [1:0] pins_s;
	logic       sck_s;
	logic       di_s;
	logic       sck_p_q;
	logic       di_p_q;

	ssi_sync2 #(.WIDTH(2)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({shift_clock_pin_i, data_in_pin_i}),
		.sync_q   (pins_s)
	);

	assign sck_s = pins_s[1];
	assign di_s  = pins_s[0];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_p_q <= 1'b0;
			di_p_q  <= 1'b0;
		end
		else
		begin
			sck_p_q <= sck_s;
			di_p_q  <= di_s;
		end
	end

	wire sck_rise = sck_s && !sck_p_q;
	wire sck_fall = !sck_s && sck_p_q;

	// ==========================================================
	// Effective configuration and clock selection.
	wire ssi_ctrl_s cfg        = ctrl_wr ? ctrl_wdata : ctrl_q;
	wire            ext_clk    = cfg.external_clock_select;
	wire            two_wire   = cfg.wire_mode[1];
	wire            hold_ovf   = (cfg.wire_mode == WM_TWO_HOLD);
	wire            three_wire = (cfg.wire_mode == WM_THREE);
	wire            strobe_clk = ctrl_wr && ctrl_wdata.clock_strobe_bit;
	wire            toggle_wr  = ctrl_wr && ctrl_wdata.clock_pin_toggle_strobe;
	wire            sample_edge = cfg.clock_edge_select ? sck_fall : sck_rise;
	wire            int_tick   = cfg.clock_edge_select ? timer0_match : strobe_clk;
	wire            shift_tick = ext_clk ? sample_edge : int_tick;
	wire            edge_tick  = cfg.clock_strobe_bit ? toggle_wr : (sck_rise || sck_fall);
	wire            count_tick = ext_clk ? edge_tick : int_tick;

	// ==========================================================
	// Shift register.
	logic [7:0] shift_data_d;

	assign shift_data_d = data_wr ? data_wdata :
		(shift_tick ? {shift_data_q[6:0], di_s} : shift_data_q);

	// ==========================================================
	// Counter.
	logic [CNT_W-1:0] cnt_q;
	logic             cnt_wrap;

	ssi_counter #(.WIDTH(CNT_W)) u_cnt (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.tick     (count_tick),
		.load     (stat_wr),
		.load_val (stat_wdata.cnt),
		.cnt_q    (cnt_q),
		.wrap     (cnt_wrap)
	);

	// ==========================================================
	// Output latch.
	logic latch_q;
	wire  latch_open = !ext_clk || (sck_s == cfg.clock_edge_select);
	wire  latch_d    = latch_open ? shift_data_q[7] : latch_q;

	// ==========================================================
	// Two-wire line events and flags.
	logic start_flag_q;
	logic ovf_flag_q;
	logic stop_flag_q;
	logic start_low_q;
	logic clk_port_q;

	wire start_ev = two_wire && sck_s && di_p_q && !di_s;
	wire stop_ev  = two_wire && sck_s && !di_p_q && di_s;
	wire clr_start = stat_wr && stat_wdata.start_condition_flag;
	wire clr_ovf   = stat_wr && stat_wdata.counter_overflow_flag;
	wire clr_stop  = stat_wr && stat_wdata.stop_flag;

	wire start_flag_d = start_ev || (start_flag_q && !clr_start);
	wire ovf_flag_d   = cnt_wrap || (ovf_flag_q && !clr_ovf);
	wire stop_flag_d  = stop_ev || (stop_flag_q && !clr_stop);
	wire start_low_d  = start_flag_d && (start_low_q || sck_fall);
	wire hold_d       = two_wire && (start_low_d || (hold_ovf && ovf_flag_d));
	wire clk_port_d   = toggle_wr ? !clk_port_q : clk_port_q;
	wire collision_d  = two_wire && data_out_dir && (latch_d != di_s);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_data_q <= DATA_RST;
			ctrl_q       <= CTRL_RST;
			latch_q      <= 1'b0;
			start_flag_q <= 1'b0;
			ovf_flag_q   <= 1'b0;
			stop_flag_q  <= 1'b0;
			start_low_q  <= 1'b0;
			clk_port_q   <= 1'b0;
		end
		else
		begin
			shift_data_q <= shift_data_d;
			ctrl_q       <= ctrl_wr ? {ctrl_wdata[7:1], 1'b0} : ctrl_q;
			latch_q      <= latch_d;
			start_flag_q <= start_flag_d;
			ovf_flag_q   <= ovf_flag_d;
			stop_flag_q  <= stop_flag_d;
			start_low_q  <= start_low_d;
			clk_port_q   <= clk_port_d;
		end
	end

	// ==========================================================
	// Registered outputs.
	wire [CNT_W-1:0] cnt_next = stat_wr ? stat_wdata.cnt : (count_tick ? CNT_W'(cnt_q + 1'b1) : cnt_q);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_q             <= STAT_RST;
			data_in_pin_o_q      <= 1'b0;
			data_in_pin_oe_q     <= 1'b0;
			data_out_pin_o_q     <= 1'b0;
			data_out_pin_oe_q    <= 1'b0;
			shift_clock_pin_o_q  <= 1'b0;
			shift_clock_pin_oe_q <= 1'b0;
			start_irq_q          <= 1'b0;
			ovf_irq_q            <= 1'b0;
			idle_wake_q          <= 1'b0;
		end
		else
		begin
			status_q             <= {start_flag_d, ovf_flag_d, stop_flag_d, collision_d, cnt_next};
			data_in_pin_o_q      <= 1'b0;
			data_in_pin_oe_q     <= two_wire && data_out_dir && !latch_d;
			data_out_pin_o_q     <= latch_d;
			data_out_pin_oe_q    <= !two_wire && data_out_dir;
			shift_clock_pin_o_q  <= two_wire ? 1'b0 : clk_port_d;
			shift_clock_pin_oe_q <= two_wire ? (hold_d || (clock_dir && !clk_port_d)) : clock_dir;
			start_irq_q          <= start_flag_d && cfg.start_ie;
			ovf_irq_q            <= ovf_flag_d && cfg.ovf_ie;
			idle_wake_q          <= ovf_flag_d && cfg.ovf_ie;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	write_wins_a: assert property (data_wr |=> shift_data_q == $past(data_wdata))
		else $error("Shift register lost a software write.");
	shift_left_a: assert property (shift_tick && !data_wr |=> shift_data_q == {$past(shift_data_q[6:0]), $past(di_s)})
		else $error("Shift register did not shift left with input bit.");
	ovf_wrap_a: assert property (count_tick && !stat_wr && cnt_q == CNT_MAX |=> cnt_q == CNT_ZERO && ovf_flag_q)
		else $error("Counter wrap did not set the overflow flag.");
	both_edges_a: assert property (ext_clk && !cfg.clock_strobe_bit && (sck_rise || sck_fall) && !stat_wr && !ctrl_wr
		|=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
		else $error("External edge was not counted.");
	latch_int_a: assert property (!ext_clk |=> latch_q == $past(shift_data_q[7]))
		else $error("Latch not transparent with internal clock.");
	latch_hold_a: assert property (ext_clk && sample_edge |=> latch_q == $past(latch_q))
		else $error("Latch changed on the sampling edge.");
	status_clear_a: assert property (stat_wr && stat_wdata.counter_overflow_flag && stat_wdata.cnt == CNT_ZERO
		|=> cnt_q == CNT_ZERO && !ovf_flag_q && !status_q.counter_overflow_flag)
		else $error("Status write did not clear flag and counter.");
	three_route_a: assert property (three_wire && data_out_dir |=> data_out_pin_oe_q && !data_in_pin_oe_q)
		else $error("Three-wire output not routed to the data output pin.");
	start_set_a: assert property (start_ev |=> start_flag_q ##1 status_q.start_condition_flag || !start_flag_q)
		else $error("Start condition not flagged.");
	ovf_hold_a: assert property (hold_ovf && ovf_flag_q && !clr_ovf && !ctrl_wr |=> shift_clock_pin_oe_q && !shift_clock_pin_o_q)
		else $error("Clock not held low after overflow.");
	toggle_pin_a: assert property (toggle_wr |=> clk_port_q != $past(clk_port_q))
		else $error("Toggle strobe did not toggle the clock pin.");
	wake_req_a: assert property (cnt_wrap && cfg.ovf_ie && !ctrl_wr |=> ovf_irq_q && idle_wake_q)
		else $error("Overflow did not raise the wake request.");

	// ==========================================================
	// Routing, clock source and flag checks.
	edge_fall_a: assert property (ext_clk && cfg.clock_edge_select && sck_fall && !data_wr
		|=> shift_data_q == {$past(shift_data_q[6:0]), $past(di_s)})
		else $error("Falling edge did not shift with edge select set.");
	timer_src_a: assert property (!ext_clk && cfg.clock_edge_select && timer0_match && !stat_wr
		|=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
		else $error("Timer match did not count.");
	timer_off_a: assert property (!ext_clk && !cfg.clock_edge_select && timer0_match && !ctrl_wr && !data_wr
		|=> shift_data_q == $past(shift_data_q))
		else $error("Timer match shifted with the software source selected.");
	strobe_cnt_a: assert property (ext_clk && cfg.clock_strobe_bit && toggle_wr && !stat_wr
		|=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
		else $error("Toggle write was not counted.");
	edge_pair_a: assert property (ext_clk && !cfg.clock_strobe_bit && sample_edge && !data_wr && !stat_wr && !ctrl_wr
		|=> shift_data_q[0] == $past(di_s) && cnt_q != $past(cnt_q))
		else $error("Shift and count did not advance together.");
	latch_open_a: assert property (ext_clk && latch_open && !ctrl_wr
		|=> latch_q == $past(shift_data_q[7]))
		else $error("Open latch did not follow the msb.");
	start_hold_a: assert property (two_wire && start_low_q && !clr_start && !ctrl_wr
		|=> shift_clock_pin_oe_q && !shift_clock_pin_o_q)
		else $error("Clock not held low after start.");
	data_route_a: assert property (two_wire && data_out_dir && !ctrl_wr
		|=> !data_out_pin_oe_q && (data_in_pin_oe_q == !$past(latch_d)))
		else $error("Two-wire output not routed to the data line.");
	three_out_a: assert property (three_wire && !ctrl_wr |=> data_out_pin_o_q == $past(latch_d))
		else $error("Data output pin does not show the latch.");
	ctrl_store_a: assert property (ctrl_wr |=> ctrl_q == {$past(ctrl_wdata[7:1]), 1'b0})
		else $error("Control write not stored with strobe cleared.");
	status_cnt_a: assert property (status_q.cnt == cnt_q)
		else $error("Status counter field differs from the counter.");
	stop_flag_a: assert property (stop_ev |=> status_q.stop_flag)
		else $error("Stop condition not flagged.");
	start_irq_a: assert property (start_flag_d && cfg.start_ie |=> start_irq_q)
		else $error("Start flag did not raise its request.");
	ovf_req_a: assert property (ovf_flag_d && cfg.ovf_ie |=> ovf_irq_q)
		else $error("Overflow flag did not raise its request.");

	ovf_seen_c:   cover property (cnt_wrap);
	start_seen_c: cover property (start_ev ##[1:20] sck_fall);
	collide_c:    cover property (data_wr && shift_tick);
	ext_byte_c:   cover property (ext_clk && count_tick && cnt_q == CNT_MAX);
	hold_seen_c:  cover property (two_wire && start_low_q);

endmodule : ssi_core

`default_nettype wire

// *** verification/ssi_spi_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-wire far-end party working in clock mode 0.
module ssi_spi_partner (
	// Link.
	input  wire logic       sck,
	input  wire logic       mosi,
	output var  logic       miso,
	output var  logic       sck_out,
	// Bench side.
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	output var  logic [7:0] rx_q
);
	initial sck_out = 1'b0;

	// Samples on the rising edge, new bit into the lsb.
	always @(posedge sck or posedge load)
		if (load)
			rx_q <= load_val;
		else
			rx_q <= {rx_q[6:0], mosi};

	// Output is set on load and changes on the falling edge.
	always @(negedge sck or posedge load)
		miso <= load ? load_val[7] : rx_q[7];

	// Eight pulses, the first rising half a period after the data is set.
	task automatic gen_byte();
		repeat (8)
		begin
			#62.5;
			sck_out = 1'b1;
			#62.5;
			sck_out = 1'b0;
		end
	endtask : gen_byte
endmodule : ssi_spi_partner

`default_nettype wire

// *** verification/serial_shift_interface_three_wire_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end

module serial_shift_interface_three_wire_tb_top;
	import ssi_pkg::*;
	logic        ref_clk, rst_n, data_wr, ctrl_wr, stat_wr, data_out_dir, clock_dir, timer0_match;
	logic [7:0]  data_wdata, shift_data_q, p_val, p_rx;
	ssi_ctrl_s   ctrl_wdata, ctrl_q;
	ssi_status_s stat_wdata, status_q;
	logic        di_o, di_oe, do_o, do_oe, sck_o, sck_oe, start_irq_q, ovf_irq_q, idle_wake_q;
	logic        miso, p_sck, p_load, sck_w;
	int          error_cnt, n_tests;

	assign sck_w = sck_oe ? sck_o : p_sck;

	ssi_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .data_wr(data_wr), .data_wdata(data_wdata),
		.shift_data_q(shift_data_q), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_q(ctrl_q),
		.stat_wr(stat_wr), .stat_wdata(stat_wdata), .status_q(status_q), .data_out_dir(data_out_dir),
		.clock_dir(clock_dir), .timer0_match(timer0_match), .data_in_pin_i(miso),
		.data_in_pin_o_q(di_o), .data_in_pin_oe_q(di_oe), .data_out_pin_o_q(do_o),
		.data_out_pin_oe_q(do_oe), .shift_clock_pin_i(sck_w), .shift_clock_pin_o_q(sck_o),
		.shift_clock_pin_oe_q(sck_oe), .start_irq_q(start_irq_q), .ovf_irq_q(ovf_irq_q),
		.idle_wake_q(idle_wake_q));

	ssi_spi_partner p (.sck(sck_w), .mosi(do_o), .miso(miso), .sck_out(p_sck), .load(p_load),
		.load_val(p_val), .rx_q(p_rx));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Bus tasks.
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask : step

	task automatic wr(input int kind, input logic [7:0] v);
		data_wdata = v;
		ctrl_wdata = v;
		stat_wdata = v;
		data_wr = (kind == 0);
		ctrl_wr = (kind == 1);
		stat_wr = (kind == 2);
		step();
		{data_wr, ctrl_wr, stat_wr} = 3'h0;
		step();
	endtask : wr

	task automatic tick();
		timer0_match = 1'b1;
		step();
		timer0_match = 1'b0;
		step();
	endtask : tick

	task automatic setup(input logic [7:0] pv, input logic [7:0] dv);
		p_val = pv;
		p_load = 1'b1;
		step();
		p_load = 1'b0;
		wr(0, dv);
		wr(2, 8'h40);
	endtask : setup

	task automatic wait_ovf(input int lim);
		int i;
		for (i = 0; i < lim && status_q.counter_overflow_flag !== 1'b1; i++)
			step();
		if (status_q.counter_overflow_flag !== 1'b1)
		begin
			`CHK(status_q.counter_overflow_flag, 1'b1)
			final_report();
		end
	endtask : wait_ovf

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// ==========================================================
	// Tests.
	initial
	begin
		{rst_n, data_wr, ctrl_wr, stat_wr, timer0_match, p_load} = 6'h0;
		{data_wdata, p_val} = 16'h0;
		ctrl_wdata = 8'h00;
		stat_wdata = 8'h00;
		{data_out_dir, clock_dir} = 2'h3;
		{error_cnt, n_tests} = 0;
		repeat (8) step();
		rst_n = 1'b1;
		step();
		`CHK({shift_data_q, ctrl_q, status_q}, {DATA_RST, CTRL_RST, STAT_RST})
		wr(0, 8'ha5);
		`CHK({shift_data_q, do_o, do_oe}, {8'ha5, 2'h3})
		$display("test reset_and_write done");
		setup(8'h3c, 8'h96);
		repeat (16)
		begin
			wr(1, 8'h5b);
			repeat (6) step();
		end
		`CHK(ctrl_q, 8'h5a)
		`CHK({status_q.counter_overflow_flag, ovf_irq_q, idle_wake_q}, 3'h7)
		`CHK({shift_data_q, p_rx}, {8'h3c, 8'h96})
		$display("test master_toggle done");
		setup(8'ha1, 8'h5e);
		repeat (8)
		begin
			wr(1, 8'h51);
			repeat (2) step();
			wr(1, 8'h53);
			repeat (2) step();
		end
		`CHK({shift_data_q, p_rx}, {8'ha1, 8'h5e})
		`CHK(status_q, 8'h08)
		$display("test master_fast done");
		clock_dir = 1'b0;
		wr(1, 8'h58);
		setup(8'hc3, 8'h7e);
		p.gen_byte();
		wait_ovf(20);
		`CHK({shift_data_q, p_rx}, {8'hc3, 8'h7e})
		`CHK(ovf_irq_q, 1'b1)
		$display("test slave_external done");
		wr(1, 8'h54);
		setup(8'hff, 8'h00);
		wr(2, 8'h4f);
		tick();
		`CHK(status_q, 8'h40)
		data_wdata = 8'h12;
		data_wr = 1'b1;
		timer0_match = 1'b1;
		step();
		{data_wr, timer0_match} = 2'h0;
		step();
		`CHK(shift_data_q, 8'h12)
		tick();
		`CHK(shift_data_q, 8'h25)
		wr(2, 8'h40);
		`CHK({status_q, ovf_irq_q}, 9'h000)
		$display("test timer_source done");
		wr(1, 8'ha8);
		p.sck_out = 1'b1;
		repeat (4) step();
		p_val = 8'h00;
		p_load = 1'b1;
		step();
		p_load = 1'b0;
		repeat (4) step();
		`CHK({status_q.start_condition_flag, start_irq_q}, 2'h3)
		p.sck_out = 1'b0;
		repeat (4) step();
		`CHK({sck_oe, sck_o}, 2'h2)
		wr(2, 8'h80);
		`CHK({sck_oe, status_q.start_condition_flag}, 2'h0)
		$display("test two_wire_start done");
		final_report();
	end

	initial
	begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule : serial_shift_interface_three_wire_tb_top

`default_nettype wire
